/* File: core/aof_pkg.sv */
// Package with register offsets, field positions, reset values and serializer constants.
package aof_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [12:0] AOF_OFS_POWER_CTL = 13'h0008;
   localparam logic [12:0] AOF_OFS_OUTPUT_MODE = 13'h0014;
   localparam logic [12:0] AOF_OFS_OUTPUT_DRIVE = 13'h0015;
   localparam logic [12:0] AOF_OFS_POWER_MODE = 13'h0100;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int AOF_BIT_OFFSET_BINARY = 0;
   localparam int AOF_BIT_REDUCED_SWING = 1;
   localparam int AOF_BIT_LSB_FIRST = 2;
   localparam int AOF_BIT_PD_STATUS = 7;
   localparam int AOF_BIT_SB_STATUS = 6;
   localparam int AOF_POWER_SAVE_MSB = 2;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [1:0] AOF_RST_POWER_CTL = 2'h0;
   localparam logic [7:0] AOF_RST_OUTPUT_MODE = 8'h00;
   localparam logic [7:0] AOF_RST_OUTPUT_DRIVE = 8'h00;
   localparam logic [2:0] AOF_RST_POWER_MODE = 3'h0;

   // ************************************************************
   // Power control commands and sample framing
   // ************************************************************
   localparam logic [1:0] AOF_CMD_RUN = 2'h0;
   localparam logic [1:0] AOF_CMD_POWER_DOWN = 2'h1;
   localparam logic [1:0] AOF_CMD_STANDBY = 2'h2;
   localparam int AOF_WORD_BITS = 14;
   localparam int AOF_RAW_BITS = 16;
   localparam logic [3:0] AOF_LAST_BIT = 4'hd;
   localparam logic [3:0] AOF_FRAME_HIGH_BITS = 4'h7;
   localparam logic [13:0] AOF_MID_CODE = 14'h2000;
   localparam logic [13:0] AOF_POS_FULL_OB = 14'h3fff;

   typedef enum logic [1:0] {AOF_RUN, AOF_POWER_DOWN, AOF_STANDBY} aof_power_type;

endpackage

/* File: core/aof_output_path.sv */
// Output format, serializer and power control of a multichannel converter.

module aof_output_path
   import aof_pkg::*;
#(
   parameter int CHANNELS = 16
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Pins from outside the clock domain.
   input wire logic power_down_pin,
   input wire logic sample_clock,
   // Converter core samples, signed, one slice of aof_pkg::AOF_RAW_BITS per channel.
   input wire logic [CHANNELS*aof_pkg::AOF_RAW_BITS-1:0] core_sample,
   // Decoded serial control register port.
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [12:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Analog and driver control.
   output logic [2:0] power_saving_mode,
   output logic reference_on,
   output logic reduced_swing,
   output logic [7:0] drive_level,
   // Serial outputs, two banks of lanes.
   output logic [CHANNELS-1:0] lane_data,
   output logic [CHANNELS-1:0] lane_oe_n,
   output logic [1:0] lane_bit_clock,
   output logic [1:0] word_frame_clock,
   output logic [1:0] clock_oe_n
);
   import aof_pkg::*;

   // ************************************************************
   // Functions
   // ************************************************************

   // Clamp a signed raw sample and code it; saturation keeps wrap-around out of the word.
   function automatic logic [13:0] code_word(input logic [15:0] raw, input logic offset_binary);
      logic [13:0] ob;
      ob = 14'h0000;
      if ($signed(raw) > $signed({2'b00, AOF_MID_CODE - 14'h0001}))
         ob = AOF_POS_FULL_OB;
      else if ($signed(raw) < -$signed({2'b00, AOF_MID_CODE}))
         ob = 14'h0000;
      else
         ob = raw[13:0] ^ AOF_MID_CODE;
      code_word = offset_binary ? ob : (ob ^ AOF_MID_CODE);
   endfunction

   // Pick the bit that goes out at a given position of the word.
   function automatic logic pick_bit(input logic [13:0] w, input logic [3:0] idx, input logic lsb_first);
      pick_bit = lsb_first ? w[idx] : w[AOF_LAST_BIT - idx];
   endfunction

   // ************************************************************
   // Synchronisers
   // ************************************************************
   logic pd_meta_q, pd_sync_q, sc_meta_q, sc_sync_q, sc_prev_q;

   // Both pins pass two flip-flops; the second stage is looked at, plus a third stage for the sample clock edge.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pd_meta_q <= 1'b0;
         pd_sync_q <= 1'b0;
         sc_meta_q <= 1'b0;
         sc_sync_q <= 1'b0;
         sc_prev_q <= 1'b0;
      end
      else
      begin
         pd_meta_q <= power_down_pin;
         pd_sync_q <= pd_meta_q;
         sc_meta_q <= sample_clock;
         sc_sync_q <= sc_meta_q;
         sc_prev_q <= sc_sync_q;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   logic [1:0] power_cmd_q;
   logic [7:0] output_mode_q, drive_q;
   logic [2:0] power_mode_q;
   logic [7:0] rdata_q;
   aof_power_type power_q;

   // Register writes; unmapped addresses are ignored.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         power_cmd_q <= AOF_RST_POWER_CTL;
         output_mode_q <= AOF_RST_OUTPUT_MODE;
         drive_q <= AOF_RST_OUTPUT_DRIVE;
         power_mode_q <= AOF_RST_POWER_MODE;
      end
      else if (reg_wr)
      begin
         if (reg_addr == AOF_OFS_POWER_CTL)
            power_cmd_q <= reg_wdata[1:0];
         else if (reg_addr == AOF_OFS_OUTPUT_MODE)
            output_mode_q <= {5'h00, reg_wdata[2:0]};
         else if (reg_addr == AOF_OFS_OUTPUT_DRIVE)
            drive_q <= reg_wdata;
         else if (reg_addr == AOF_OFS_POWER_MODE)
            power_mode_q <= reg_wdata[AOF_POWER_SAVE_MSB:0];
      end
   end

   // Read data is registered; the power control word also shows the live power state.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         if (reg_addr == AOF_OFS_POWER_CTL)
            rdata_q <= {power_q == AOF_POWER_DOWN, power_q == AOF_STANDBY, 4'h0, power_cmd_q};
         else if (reg_addr == AOF_OFS_OUTPUT_MODE)
            rdata_q <= output_mode_q;
         else if (reg_addr == AOF_OFS_OUTPUT_DRIVE)
            rdata_q <= drive_q;
         else if (reg_addr == AOF_OFS_POWER_MODE)
            rdata_q <= {5'h00, power_mode_q};
         else
            rdata_q <= 8'h00;
      end
   end

   // ************************************************************
   // Power state
   // ************************************************************

   // The pin wins over standby; dropping the pin returns to whatever the command word asks.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         power_q <= AOF_RUN;
      else if (pd_sync_q || power_cmd_q == AOF_CMD_POWER_DOWN)
         power_q <= AOF_POWER_DOWN;
      else if (power_cmd_q == AOF_CMD_STANDBY)
         power_q <= AOF_STANDBY;
      else
         power_q <= AOF_RUN;
   end

   logic ref_on_q;

   // The reference stays up in standby, so only a full power-down drops it.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ref_on_q <= 1'b1;
      else
         ref_on_q <= (power_q != AOF_POWER_DOWN);
   end

   // ************************************************************
   // Sample capture and serializer
   // ************************************************************
   logic [CHANNELS*AOF_RAW_BITS-1:0] held_q;
   logic [CHANNELS*AOF_WORD_BITS-1:0] word_q;
   logic [3:0] bit_q;
   logic lsb_first_q;
   logic running;

   assign running = (power_q == AOF_RUN);

   // Each rising sample clock edge latches the newest conversion results.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         held_q <= '0;
      else if (sc_sync_q && !sc_prev_q)
         held_q <= core_sample;
   end

   // Bit position; held at the first bit while idle so output restarts on a frame.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         bit_q <= 4'h0;
      else if (!running || bit_q == AOF_LAST_BIT)
         bit_q <= 4'h0;
      else
         bit_q <= bit_q + 4'h1;
   end

   // Words and bit order are loaded only at position zero, so settings switch per word.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         word_q <= '0;
         lsb_first_q <= 1'b0;
      end
      else if (bit_q == 4'h0)
      begin
         lsb_first_q <= output_mode_q[AOF_BIT_LSB_FIRST];
         for (int c = 0; c < CHANNELS; c++)
            word_q[c*AOF_WORD_BITS +: AOF_WORD_BITS] <=
               code_word(held_q[c*AOF_RAW_BITS +: AOF_RAW_BITS], output_mode_q[AOF_BIT_OFFSET_BINARY]);
      end
   end

   // ************************************************************
   // Output pins
   // ************************************************************
   logic [CHANNELS-1:0] lane_q, lane_oe_n_q;
   logic [1:0] bclk_q, fclk_q, clk_oe_n_q;

   // The word loaded this cycle is used at position zero, so bit zero is never stale.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lane_q <= '0;
         lane_oe_n_q <= '1;
         bclk_q <= 2'h0;
         fclk_q <= 2'h0;
         clk_oe_n_q <= 2'h3;
      end
      else
      begin
         for (int c = 0; c < CHANNELS; c++)
            lane_q[c] <= running & pick_bit((bit_q == 4'h0) ?
               code_word(held_q[c*AOF_RAW_BITS +: AOF_RAW_BITS], output_mode_q[AOF_BIT_OFFSET_BINARY]) :
               word_q[c*AOF_WORD_BITS +: AOF_WORD_BITS],
               bit_q, (bit_q == 4'h0) ? output_mode_q[AOF_BIT_LSB_FIRST] : lsb_first_q);
         lane_oe_n_q <= {CHANNELS{!running}};
         clk_oe_n_q <= {2{!running}};
         bclk_q <= running ? ~bclk_q : 2'h0;
         fclk_q <= {2{running && bit_q < AOF_FRAME_HIGH_BITS}};
      end
   end

   // ************************************************************
   // Output assignments
   // ************************************************************
   assign reg_rdata = rdata_q;
   assign power_saving_mode = power_mode_q;
   assign reference_on = ref_on_q;
   assign reduced_swing = output_mode_q[AOF_BIT_REDUCED_SWING];
   assign drive_level = drive_q;
   assign lane_data = lane_q;
   assign lane_oe_n = lane_oe_n_q;
   assign lane_bit_clock = bclk_q;
   assign word_frame_clock = fclk_q;
   assign clock_oe_n = clk_oe_n_q;

endmodule

/* File: verification/aof_output_path_properties.sv */
// Port checker for the output path.
module aof_output_path_properties
   import aof_pkg::*;
#(
   parameter int CHANNELS = 16
)
(
   // Watched ports.
   input wire logic clk,
   input wire logic rstn,
   input wire logic power_down_pin,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [12:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] power_saving_mode,
   input wire logic reference_on,
   input wire logic reduced_swing,
   input wire logic [7:0] drive_level,
   input wire logic [CHANNELS-1:0] lane_data,
   input wire logic [CHANNELS-1:0] lane_oe_n,
   input wire logic [1:0] lane_bit_clock,
   input wire logic [1:0] word_frame_clock,
   input wire logic [1:0] clock_oe_n
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Five samples cover two sync stages, the state flop and the output flop.
   sequence pin_held;
      power_down_pin [*5];
   endsequence
   sequence word_on;
      (word_frame_clock[0] && !lane_oe_n[0]) [*7] ##1 (!word_frame_clock[0] && !lane_oe_n[0]) [*7];
   endsequence
   a_pd_float: assert property (pin_held |-> &lane_oe_n && &clock_oe_n) else $error("outputs driven");
   a_pd_ref: assert property (pin_held |-> !reference_on) else $error("reference on");
   a_float_zero: assert property (&lane_oe_n |-> lane_data == '0 && lane_bit_clock == 2'h0) else $error("float");
   a_bclk_toggle: assert property (!lane_oe_n[0] ##1 !lane_oe_n[0] |-> lane_bit_clock[0] != $past(lane_bit_clock[0]))
      else $error("bit clock stalled");
   a_frame_shape: assert property ($rose(word_frame_clock[0]) |-> (word_on ##1 word_frame_clock[0])
      or (##[1:14] lane_oe_n[0])) else $error("frame shape");
   a_resume_frame: assert property ($fell(lane_oe_n[0]) |-> word_frame_clock[0]) else $error("resume");
   a_bank_match: assert property (lane_bit_clock[0] == lane_bit_clock[1] &&
      word_frame_clock[0] == word_frame_clock[1]) else $error("banks");
   a_mode_write: assert property (reg_wr && reg_addr == AOF_OFS_POWER_MODE |=>
      power_saving_mode == $past(reg_wdata[2:0])) else $error("power mode");
   a_drive_write: assert property (reg_wr && reg_addr == AOF_OFS_OUTPUT_DRIVE |=>
      drive_level == $past(reg_wdata)) else $error("drive");
   a_swing_write: assert property (reg_wr && reg_addr == AOF_OFS_OUTPUT_MODE |=>
      reduced_swing == $past(reg_wdata[1])) else $error("swing");
endmodule

/* File: verification/aof_lane_receiver.sv */
// Receiver model that rebuilds lane words against the frame clock.
module aof_lane_receiver
(
   // Lane inputs.
   input wire logic clk,
   input wire logic lane,
   input wire logic bclk,
   input wire logic frame,
   input wire logic oe_n,
   // Rebuilt word and word count.
   output logic [13:0] word,
   output int count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic frame_q = 1'b0;
   logic bclk_q = 1'b0;
   logic [13:0] sr = 14'h0000;
   int pos = 0;
   int count_q = 0;
   assign count = count_q;
   // A bit is taken only where the bit clock changed, so both of its edges carry data.
   // A frame rise restarts the word, so no stale bits leak in.
   always @(posedge clk)
   begin
      frame_q <= frame;
      bclk_q <= bclk;
      if (oe_n)
         pos <= 0;
      else if (bclk != bclk_q)
      begin
         if (frame && !frame_q)
         begin
            sr <= {13'h0000, lane};
            pos <= 1;
         end
         else if (pos > 0)
         begin
            sr <= {sr[12:0], lane};
            pos <= (pos == 13) ? 0 : pos + 1;
            if (pos == 13)
            begin
               word <= {sr[12:0], lane};
               count_q <= count_q + 1;
            end
         end
      end
   end
endmodule

/* File: verification/tb_top.sv */
// Testbench for the output path.
module tb_top;
   import aof_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CH = 4;
   logic clk = 1'b0, rstn = 1'b0, power_down_pin = 1'b0, sample_clock = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [CH*16-1:0] core_sample = '0;
   logic [12:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata, drive_level, d;
   logic [2:0] power_saving_mode;
   logic reference_on, reduced_swing;
   logic [CH-1:0] lane_data, lane_oe_n;
   logic [1:0] lane_bit_clock, word_frame_clock, clock_oe_n;
   logic [13:0] rx_word, rx_last;
   logic signed [15:0] raws [5] = '{16'sd0, 16'sd8191, 16'sd9000, -16'sd8192, -16'sd9000};
   logic [7:0] modes [3] = '{8'h00, 8'h01, 8'h04};
   int rx_count, err_count = 0, checks_done = 0, cyc = 0;
   // ****************************************
   // Clocks, instances and shared tasks
   // ****************************************
   initial forever #25 clk = ~clk;
   initial forever #200 sample_clock = ~sample_clock;
   aof_output_path #(.CHANNELS(CH)) aof_output_path_inst (.clk(clk), .rstn(rstn), .power_down_pin(power_down_pin),
      .sample_clock(sample_clock), .core_sample(core_sample), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_saving_mode(power_saving_mode),
      .reference_on(reference_on), .reduced_swing(reduced_swing), .drive_level(drive_level), .lane_data(lane_data),
      .lane_oe_n(lane_oe_n), .lane_bit_clock(lane_bit_clock), .word_frame_clock(word_frame_clock),
      .clock_oe_n(clock_oe_n));
   aof_lane_receiver aof_lane_receiver_inst (.clk(clk), .lane(lane_data[0]), .bclk(lane_bit_clock[0]),
      .frame(word_frame_clock[0]), .oe_n(lane_oe_n[0]), .word(rx_word), .count(rx_count));
   // A second receiver on the last lane, clocked by the second bank's clocks.
   aof_lane_receiver aof_lane_receiver_last_inst (.clk(clk), .lane(lane_data[CH-1]), .bclk(lane_bit_clock[1]),
      .frame(word_frame_clock[1]), .oe_n(lane_oe_n[CH-1]), .word(rx_last), .count());
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [12:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask
   // Waits for n whole words, so the latest sample and settings have reached the lane.
   task automatic words(input int n);
      int k;
      k = rx_count + n;
      repeat (600) if (rx_count < k) @(posedge clk);
   endtask
   // Expected lane word: clamp, recode, then reverse for LSB first.
   function automatic logic [13:0] expw(input logic signed [15:0] r, input logic [7:0] m);
      logic [13:0] w;
      w = r > 8191 ? 14'h1fff : (r < -8192 ? 14'h2000 : r[13:0]);
      if (m[0]) w = w ^ 14'h2000;
      if (m[2]) w = {<<{w}};
      return w;
   endfunction
   task automatic test_done;
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         test_done;
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(AOF_OFS_OUTPUT_DRIVE, d);
      chk("drive reset", AOF_RST_OUTPUT_DRIVE, d);
      rd(AOF_OFS_POWER_MODE, d);
      chk("power mode reset", {5'h00, AOF_RST_POWER_MODE}, d);
      rd(13'h00aa, d);
      chk("unmapped read", 8'h00, d);
      rd(AOF_OFS_POWER_CTL, d);
      chk("power reset", 8'h00, d);
      rd(AOF_OFS_OUTPUT_MODE, d);
      chk("mode reset", AOF_RST_OUTPUT_MODE, d);
      chk("swing reset", 1'b0, reduced_swing);
      wr(AOF_OFS_POWER_MODE, 8'h05);
      rd(AOF_OFS_POWER_MODE, d);
      chk("power mode", 8'h05, d);
      chk("saving mode", 3'h5, power_saving_mode);
      wr(AOF_OFS_OUTPUT_DRIVE, 8'ha5);
      @(posedge clk);
      chk("drive", 8'ha5, drive_level);
      rd(AOF_OFS_OUTPUT_DRIVE, d);
      chk("drive read", 8'ha5, d);
      wr(AOF_OFS_OUTPUT_MODE, 8'hfa);
      @(posedge clk);
      chk("swing", 1'b1, reduced_swing);
      rd(AOF_OFS_OUTPUT_MODE, d);
      chk("mode read", 8'h02, d);
      foreach (modes[m])
         foreach (raws[v])
         begin
            wr(AOF_OFS_OUTPUT_MODE, modes[m]);
            core_sample <= {CH{raws[v]}};
            words(3);
            chk("word", expw(raws[v], modes[m]), rx_word);
            chk("word last lane", expw(raws[v], modes[m]), rx_last);
         end
      power_down_pin <= 1'b1;
      repeat (8) @(posedge clk);
      chk("pd float", {CH + 3{1'b1}}, {lane_oe_n, clock_oe_n, !reference_on});
      rd(AOF_OFS_POWER_CTL, d);
      chk("pd status", 8'h80, d);
      power_down_pin <= 1'b0;
      words(2);
      chk("resume", expw(raws[4], modes[2]), rx_word);
      wr(AOF_OFS_POWER_CTL, {6'h00, AOF_CMD_POWER_DOWN});
      repeat (4) @(posedge clk);
      chk("cmd float", {CH + 3{1'b1}}, {lane_oe_n, clock_oe_n, !reference_on});
      rd(AOF_OFS_POWER_CTL, d);
      chk("cmd status", 8'h81, d);
      wr(AOF_OFS_POWER_CTL, {6'h00, AOF_CMD_STANDBY});
      repeat (4) @(posedge clk);
      chk("standby", {CH + 3{1'b1}}, {lane_oe_n, clock_oe_n, reference_on});
      rd(AOF_OFS_POWER_CTL, d);
      chk("standby status", 8'h42, d);
      wr(AOF_OFS_POWER_CTL, {6'h00, AOF_CMD_RUN});
      words(2);
      chk("wake", expw(raws[4], modes[2]), rx_word);
      test_done;
   end
endmodule
bind aof_output_path aof_output_path_properties #(.CHANNELS(CHANNELS)) aof_output_path_properties_inst (.clk(clk),
   .rstn(rstn), .power_down_pin(power_down_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_saving_mode(power_saving_mode), .reference_on(reference_on),
   .reduced_swing(reduced_swing), .drive_level(drive_level), .lane_data(lane_data), .lane_oe_n(lane_oe_n),
   .lane_bit_clock(lane_bit_clock), .word_frame_clock(word_frame_clock), .clock_oe_n(clock_oe_n));
